// *** hw/cag_consts.svh ***
// register offsets, field positions, reset values and map limits of the address block
`ifndef CAG_CONSTS_SVH
`define CAG_CONSTS_SVH

`define CAG_OFF_SYSCTL 4'h0
`define CAG_OFF_PC 4'h4
`define CAG_OFF_INDEX 4'h8
`define CAG_OFF_OPTION 4'hC

`define CAG_SR0_RST 8'h00
`define CAG_SR0_EID 0
`define CAG_SR0_IDB 2
`define CAG_SR0_GRB_HI 4
`define CAG_SR0_GRB_LO 3

`define CAG_PC_RST 20'h00000
`define CAG_OPT_ADDR_LO 20'h0001E
`define CAG_OPT_ADDR_HI 20'h0001F
`define CAG_VEC_LAST 20'h00004
`define CAG_PROG_START 20'h00020
`define CAG_PROG_TOP 20'h01FFF

`define CAG_OPT_BT_HI 14
`define CAG_OPT_BT_LO 12
`define CAG_OPT_WDT 11
`define CAG_OPT_BLANK 16'hFFFF

`define CAG_PERIPH_TOP 16'h007F
`define CAG_LCD_BASE 16'h0200
`define CAG_LCD_TOP 16'h020F

`endif

// *** hw/cag_pkg.sv ***
// types shared by the address generation block
package cag_pkg;

    typedef enum logic [2:0] {
        CAG_PC_HOLD = 3'h0,
        CAG_PC_SEQ = 3'h1,
        CAG_PC_LONG = 3'h2,
        CAG_PC_REL = 3'h3,
        CAG_PC_VEC = 3'h4
    } cag_pc_op_t;

    // long: target[19:0]; rel: target[11:0] offset; vec: target[2:0] index
    typedef struct packed {
        cag_pc_op_t op;
        logic [19:0] target;
    } cag_pc_cmd_t;

    typedef struct packed {
        logic valid;
        logic indexed;
        logic second;
        logic modify;
        logic [7:0] delta;
        logic [7:0] adr;
    } cag_data_cmd_t;

    typedef enum logic [1:0] {
        CAG_SPR_INDEX_OFFSET_FIRST = 2'h0,
        CAG_SPR_INDEX_OFFSET_SECOND = 2'h1,
        CAG_SPR_IDH = 2'h2,
        CAG_SPR_SR0 = 2'h3
    } cag_spr_t;

    typedef struct packed {
        logic wr_en;
        logic [1:0] wr_sel;
        logic [7:0] wr_data;
        logic [1:0] rd_a;
        logic [1:0] rd_b;
        logic to_spr;
        logic from_spr;
        cag_spr_t special_register;
    } cag_rf_cmd_t;

    typedef enum logic [1:0] {
        CAG_BOOT_A = 2'h0,
        CAG_BOOT_B = 2'h1,
        CAG_BOOT_C = 2'h2,
        CAG_RUN = 2'h3
    } cag_boot_t;

endpackage

// *** hw/cag_core_addr.sv ***
// program counter sequencing, data address forming and banked registers
// Function
// R1: drive 20-bit program word address, 256 pages of 4K words.
// R2: pc[19:12] is page, pc[11:0] is offset in page.
// R3: sequential step at page end wraps to offset zero, same page.
// R4: only long call, link and jump load full 20-bit target.
// R5: relative branches add on 12-bit offset only, page untouched.
// R6: drive 16-bit data byte address, high byte page, low byte offset.
// R7: indexed address is index page byte joined with first or second offset.
// R8: direct address takes offset from instruction address field.
// R9: direct page is zero when eid clear, else active bank page byte.
// R10: index modification adds over full 16 bits, writes both bytes back.
// R11: four banks of four general registers, bank from grb field.
// R12: both ALU operands come from the same active bank.
// R13: special registers moved to and from general registers, not ALU operands.
// R14: two index banks with own page byte and two offsets, idb selects.
// R15: program words 0 to 4 are vectors, rest below program area reserved.
// R16: 8K words implemented, normal code from 0x00020 to 0x01FFF.
// R17: after reset read option words 0x1E and 0x1F before running.
// R18: option bits 14..12 give basic timer reset divider.
// R19: option bit 11 gives watchdog enable from reset.
// R20: unprogrammed option words read all ones, bits default to one.
// R21: data 0x0000-0x007F peripheral, 0x0200-0x020F display memory.
// R22: bank selects take effect next instruction, used directly by reads.
`timescale 1ns/1ps
`include "cag_consts.svh"

module cag_core_addr (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire cag_pkg::cag_pc_cmd_t pc_cmd_i,
    input wire cag_pkg::cag_data_cmd_t data_cmd_i,
    input wire cag_pkg::cag_rf_cmd_t rf_cmd_i,
    input wire logic [15:0] prog_rdata_i,
    output logic [19:0] program_word_address_o,
    output logic prog_out_of_range_o,
    output logic boot_done_o,
    output logic [15:0] data_byte_address_o,
    output logic data_periph_o,
    output logic data_lcd_o,
    output logic [7:0] gpr_rd_a_o,
    output logic [7:0] gpr_rd_b_o,
    output logic [7:0] spr_rd_o,
    output logic [2:0] bt_div_sel_o,
    output logic wdt_enable_o
);

    // ==========================================
    // state
    cag_pkg::cag_boot_t boot_q;
    logic [19:0] pc_q;
    logic [7:0] sr0_q;
    logic [7:0] idh_q [2];
    logic [7:0] index_offset_first_q [2];
    logic [7:0] index_offset_second_q [2];
    logic [7:0] gpr_q [16];
    logic [15:0] opt_lo_q;
    logic [15:0] opt_hi_q;
    logic wait_q;
    logic run;
    logic idb;
    logic [1:0] grb;
    logic [7:0] act_idh;
    logic [7:0] act_off;
    logic [15:0] idx_addr;
    logic [15:0] idx_sum;
    logic [15:0] data_d;
    logic [19:0] pc_d;
    logic [7:0] spr_val;
    logic [7:0] gpr_src;
    logic bus_req;
    logic bus_wr_now;

    assign run = (boot_q == cag_pkg::CAG_RUN);
    // bank selects straight from the live status register
    assign idb = sr0_q[`CAG_SR0_IDB]; // [R22]
    assign grb = sr0_q[`CAG_SR0_GRB_HI:`CAG_SR0_GRB_LO]; // [R11]
    assign act_idh = idh_q[idb]; // [R14]
    assign act_off = data_cmd_i.second ? index_offset_second_q[idb] : index_offset_first_q[idb];
    assign idx_addr = {act_idh, act_off}; // [R7]
    // full 16-bit carry, no page wrap
    assign idx_sum = idx_addr + {{8{data_cmd_i.delta[7]}}, data_cmd_i.delta}; // [R10]
    assign gpr_src = gpr_q[{grb, rf_cmd_i.rd_a}];
    assign bus_req = avs_read_i | avs_write_i;
    assign bus_wr_now = avs_write_i & ~wait_q;

    // ==========================================
    // boot option fetch
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            boot_q <= cag_pkg::CAG_BOOT_A;
        end else begin
            unique case (boot_q)
                cag_pkg::CAG_BOOT_A: boot_q <= cag_pkg::CAG_BOOT_B;
                cag_pkg::CAG_BOOT_B: boot_q <= cag_pkg::CAG_BOOT_C;
                cag_pkg::CAG_BOOT_C: boot_q <= cag_pkg::CAG_RUN;
                cag_pkg::CAG_RUN: boot_q <= cag_pkg::CAG_RUN;
            endcase
        end
    end

    // rom data follows its address by one cycle
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            opt_lo_q <= `CAG_OPT_BLANK; // [R20]
            opt_hi_q <= `CAG_OPT_BLANK; // [R20]
        end else if (boot_q == cag_pkg::CAG_BOOT_B) begin
            opt_lo_q <= prog_rdata_i; // [R17]
        end else if (boot_q == cag_pkg::CAG_BOOT_C) begin
            opt_hi_q <= prog_rdata_i; // [R17]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            bt_div_sel_o <= 3'h7;
            wdt_enable_o <= 1'b1;
            boot_done_o <= 1'b0;
        end else begin
            bt_div_sel_o <= opt_hi_q[`CAG_OPT_BT_HI:`CAG_OPT_BT_LO]; // [R18]
            wdt_enable_o <= opt_hi_q[`CAG_OPT_WDT]; // [R19]
            boot_done_o <= run;
        end
    end

    // ==========================================
    // program counter
    always_comb begin
        pc_d = pc_q;
        unique case (pc_cmd_i.op)
            cag_pkg::CAG_PC_HOLD: pc_d = pc_q;
            cag_pkg::CAG_PC_SEQ: pc_d = {pc_q[19:12], pc_q[11:0] + 12'h001}; // [R3]
            cag_pkg::CAG_PC_LONG: pc_d = pc_cmd_i.target; // [R4]
            cag_pkg::CAG_PC_REL: pc_d = {pc_q[19:12], pc_q[11:0] + pc_cmd_i.target[11:0]}; // [R5]
            cag_pkg::CAG_PC_VEC: begin
                pc_d = {17'h00000, pc_cmd_i.target[2:0]}; // [R15]
                if (pc_d > `CAG_VEC_LAST) begin
                    pc_d = `CAG_VEC_LAST;
                end
            end
            default: pc_d = pc_q;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pc_q <= `CAG_OPT_ADDR_LO;
        end else if (boot_q == cag_pkg::CAG_BOOT_A) begin
            pc_q <= `CAG_OPT_ADDR_HI; // [R17]
        end else if (boot_q == cag_pkg::CAG_BOOT_B) begin
            pc_q <= `CAG_PC_RST;
        end else if (run) begin
            pc_q <= pc_d; // [R2]
        end
    end

    // address out is the page:offset counter itself
    assign program_word_address_o = pc_q; // [R1]

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            prog_out_of_range_o <= 1'b0;
        end else begin
            prog_out_of_range_o <= run & (pc_d > `CAG_PROG_TOP); // [R16]
        end
    end

    // ==========================================
    // data address
    always_comb begin
        if (data_cmd_i.indexed) begin
            data_d = idx_addr; // [R7]
        end else if (sr0_q[`CAG_SR0_EID]) begin
            data_d = {act_idh, data_cmd_i.adr}; // [R8] [R9]
        end else begin
            data_d = {8'h00, data_cmd_i.adr}; // [R9]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            data_byte_address_o <= 16'h0000;
            data_periph_o <= 1'b0;
            data_lcd_o <= 1'b0;
        end else if (data_cmd_i.valid && run) begin
            data_byte_address_o <= data_d; // [R6]
            data_periph_o <= (data_d <= `CAG_PERIPH_TOP); // [R21]
            data_lcd_o <= (data_d >= `CAG_LCD_BASE) && (data_d <= `CAG_LCD_TOP); // [R21]
        end
    end

    // ==========================================
    // index banks
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 2; i++) begin
                idh_q[i] <= 8'h00;
                index_offset_first_q[i] <= 8'h00;
                index_offset_second_q[i] <= 8'h00;
            end
        end else if (run && data_cmd_i.valid && data_cmd_i.indexed && data_cmd_i.modify) begin
            idh_q[idb] <= idx_sum[15:8]; // [R10]
            if (data_cmd_i.second) begin
                index_offset_second_q[idb] <= idx_sum[7:0];
            end else begin
                index_offset_first_q[idb] <= idx_sum[7:0];
            end
        end else if (run && rf_cmd_i.to_spr) begin
            unique case (rf_cmd_i.special_register)
                cag_pkg::CAG_SPR_INDEX_OFFSET_FIRST: index_offset_first_q[idb] <= gpr_src; // [R13]
                cag_pkg::CAG_SPR_INDEX_OFFSET_SECOND: index_offset_second_q[idb] <= gpr_src;
                cag_pkg::CAG_SPR_IDH: idh_q[idb] <= gpr_src;
                cag_pkg::CAG_SPR_SR0: ;
            endcase
        end else if (bus_wr_now && avs_address_i == `CAG_OFF_INDEX) begin
            index_offset_first_q[idb] <= avs_writedata_i[7:0];
            index_offset_second_q[idb] <= avs_writedata_i[15:8];
            idh_q[idb] <= avs_writedata_i[23:16];
        end
    end

    // ==========================================
    // system control flags
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sr0_q <= `CAG_SR0_RST;
        end else if (run && rf_cmd_i.to_spr && rf_cmd_i.special_register == cag_pkg::CAG_SPR_SR0) begin
            sr0_q <= gpr_src; // [R13]
        end else if (bus_wr_now && avs_address_i == `CAG_OFF_SYSCTL) begin
            sr0_q <= avs_writedata_i[7:0];
        end
    end

    always_comb begin
        unique case (rf_cmd_i.special_register)
            cag_pkg::CAG_SPR_INDEX_OFFSET_FIRST: spr_val = index_offset_first_q[idb];
            cag_pkg::CAG_SPR_INDEX_OFFSET_SECOND: spr_val = index_offset_second_q[idb];
            cag_pkg::CAG_SPR_IDH: spr_val = idh_q[idb];
            cag_pkg::CAG_SPR_SR0: spr_val = sr0_q;
        endcase
    end

    // ==========================================
    // general registers, one generate slice per register
    for (genvar g = 0; g < 16; g++) begin : g_gpr
        always_ff @(posedge mclk_i) begin
            if (sys_rst_i) begin
                gpr_q[g] <= 8'h00;
            end else if (run && rf_cmd_i.from_spr && g == {grb, rf_cmd_i.rd_a}) begin
                gpr_q[g] <= spr_val; // [R13]
            end else if (run && rf_cmd_i.wr_en && g == {grb, rf_cmd_i.wr_sel}) begin
                gpr_q[g] <= rf_cmd_i.wr_data; // [R11]
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            gpr_rd_a_o <= 8'h00;
            gpr_rd_b_o <= 8'h00;
            spr_rd_o <= 8'h00;
        end else begin
            gpr_rd_a_o <= gpr_q[{grb, rf_cmd_i.rd_a}]; // [R12]
            gpr_rd_b_o <= gpr_q[{grb, rf_cmd_i.rd_b}]; // [R12]
            spr_rd_o <= spr_val;
        end
    end

    // ==========================================
    // avalon slave, one wait cycle per access
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wait_q <= 1'b1;
            avs_readdata_o <= 32'h00000000;
        end else if (bus_req && wait_q) begin
            wait_q <= 1'b0;
            unique case (avs_address_i)
                `CAG_OFF_SYSCTL: avs_readdata_o <= {24'h000000, sr0_q};
                `CAG_OFF_PC: avs_readdata_o <= {9'h000, ~run, 2'h0, pc_q};
                `CAG_OFF_INDEX: avs_readdata_o <= {8'h00, act_idh, index_offset_second_q[idb], index_offset_first_q[idb]};
                `CAG_OFF_OPTION: avs_readdata_o <= {opt_hi_q, opt_lo_q};
                default: avs_readdata_o <= 32'h00000000;
            endcase
        end else begin
            wait_q <= 1'b1;
        end
    end

    assign avs_waitrequest_o = wait_q;

    // ==========================================
    // checks
    property p_seq_wrap; // [R3]
        @(posedge mclk_i) disable iff (sys_rst_i)
        run && pc_cmd_i.op == cag_pkg::CAG_PC_SEQ |=>
            pc_q == {$past(pc_q[19:12]), $past(pc_q[11:0]) + 12'h001};
    endproperty
    a_seq_wrap: assert property (p_seq_wrap) else $error("sequential step left page"); // [R3]

    property p_long; // [R4]
        @(posedge mclk_i) disable iff (sys_rst_i)
        run && pc_cmd_i.op == cag_pkg::CAG_PC_LONG |=> pc_q == $past(pc_cmd_i.target);
    endproperty
    a_long: assert property (p_long) else $error("long branch target not loaded"); // [R4]

    property p_rel_page; // [R5]
        @(posedge mclk_i) disable iff (sys_rst_i)
        run && pc_cmd_i.op != cag_pkg::CAG_PC_LONG && pc_cmd_i.op != cag_pkg::CAG_PC_VEC
            |=> $stable(pc_q[19:12]);
    endproperty
    a_rel_page: assert property (p_rel_page) else $error("page changed by short step"); // [R5]

    property p_direct_page; // [R9]
        @(posedge mclk_i) disable iff (sys_rst_i)
        run && data_cmd_i.valid && !data_cmd_i.indexed && !sr0_q[`CAG_SR0_EID]
            |=> data_byte_address_o == {8'h00, $past(data_cmd_i.adr)};
    endproperty
    a_direct_page: assert property (p_direct_page) else $error("direct page not zero"); // [R9]

    property p_index_addr; // [R7]
        @(posedge mclk_i) disable iff (sys_rst_i)
        run && data_cmd_i.valid && data_cmd_i.indexed |=> data_byte_address_o == $past(idx_addr);
    endproperty
    a_index_addr: assert property (p_index_addr) else $error("indexed address wrong"); // [R7]

    property p_modify; // [R10]
        @(posedge mclk_i) disable iff (sys_rst_i)
        run && data_cmd_i.valid && data_cmd_i.indexed && data_cmd_i.modify && !data_cmd_i.second
            && !$past(sys_rst_i) |=> {idh_q[idb], index_offset_first_q[idb]} == $past(idx_sum);
    endproperty
    a_modify: assert property (p_modify) else $error("index pair not carried"); // [R10]

    property p_option; // [R18]
        @(posedge mclk_i) disable iff (sys_rst_i)
        run ##1 run |-> bt_div_sel_o == opt_hi_q[14:12] && wdt_enable_o == opt_hi_q[11];
    endproperty
    a_option: assert property (p_option) else $error("option bits not applied"); // [R18]

    property p_boot_len; // [R17]
        @(posedge mclk_i) $fell(sys_rst_i) |-> !run ##1 !run ##1 !run ##1 run;
    endproperty
    a_boot_len: assert property (p_boot_len) else $error("boot fetch length wrong"); // [R17]

    property p_gpr_bank; // [R12]
        @(posedge mclk_i) disable iff (sys_rst_i)
        !$past(sys_rst_i) |-> gpr_rd_a_o == $past(gpr_q[{grb, rf_cmd_i.rd_a}]);
    endproperty
    a_gpr_bank: assert property (p_gpr_bank) else $error("operand from wrong bank"); // [R12]

    property p_gpr_pair; // [R12]
        @(posedge mclk_i) disable iff (sys_rst_i)
        run && rf_cmd_i.rd_a == rf_cmd_i.rd_b |=> gpr_rd_a_o == gpr_rd_b_o;
    endproperty
    a_gpr_pair: assert property (p_gpr_pair) else $error("operands from mixed banks"); // [R12]

    property p_rel_target; // [R5]
        @(posedge mclk_i) disable iff (sys_rst_i)
        run && pc_cmd_i.op == cag_pkg::CAG_PC_REL |=>
            pc_q[11:0] == $past(pc_q[11:0]) + $past(pc_cmd_i.target[11:0]);
    endproperty
    a_rel_target: assert property (p_rel_target) else $error("relative offset not wrapped"); // [R5]

    property p_vec_range; // [R15]
        @(posedge mclk_i) disable iff (sys_rst_i)
        run && pc_cmd_i.op == cag_pkg::CAG_PC_VEC |=> pc_q <= `CAG_VEC_LAST;
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("vector outside vector area"); // [R15]

    property p_lcd_decode; // [R21]
        @(posedge mclk_i) disable iff (sys_rst_i)
        run && data_cmd_i.valid |=> data_lcd_o == (data_byte_address_o >= `CAG_LCD_BASE
            && data_byte_address_o <= `CAG_LCD_TOP);
    endproperty
    a_lcd_decode: assert property (p_lcd_decode) else $error("display decode wrong"); // [R21]

endmodule

// *** tb/cag_prog_mem.sv ***
// program memory model facing the fetch port of the address block
`timescale 1ns/1ps
module cag_prog_mem (
    input wire logic mclk_i,
    input wire logic blank_i,
    input wire logic [15:0] opt_lo_i,
    input wire logic [15:0] opt_hi_i,
    input wire logic [19:0] addr_i,
    output logic [15:0] rdata_o
);
    initial rdata_o = 16'h0000;
    // one cycle from address to data
    always @(posedge mclk_i) begin
        if (addr_i == 20'h0001E) begin
            rdata_o <= blank_i ? 16'hFFFF : opt_lo_i;
        end else if (addr_i == 20'h0001F) begin
            rdata_o <= blank_i ? 16'hFFFF : opt_hi_i;
        end else if (addr_i > 20'h01FFF) begin
            rdata_o <= ~rdata_o;
        end else begin
            rdata_o <= addr_i[15:0] ^ 16'h5A5A;
        end
    end
endmodule

// *** tb/cag_core_addr_tb.sv ***
// self-checking bench for the address generation block
`timescale 1ns/1ps
module cag_core_addr_tb;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    cag_pkg::cag_pc_cmd_t pc_cmd_i = '0;
    cag_pkg::cag_data_cmd_t data_cmd_i = '0;
    cag_pkg::cag_rf_cmd_t rf_cmd_i = '0;
    logic [15:0] prog_rdata_i;
    logic [19:0] pa;
    logic oor, bdone, periph, lcd, wdt, blank = 1'b0;
    logic [15:0] da;
    logic [7:0] ga, gb, sp;
    logic [2:0] bt;
    logic [2:0] q_sel[$];
    logic [31:0] q_exp[$];
    logic [31:0] got, rs = 32'h15356FF7;
    logic [7:0] gv[4];
    logic [7:0] a8;
    int n_fail = 0;
    int n_compared = 0;

    always #10 mclk_i = ~mclk_i;

    cag_core_addr cag_core_addr_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .pc_cmd_i(pc_cmd_i), .data_cmd_i(data_cmd_i),
        .rf_cmd_i(rf_cmd_i), .prog_rdata_i(prog_rdata_i), .program_word_address_o(pa),
        .prog_out_of_range_o(oor), .boot_done_o(bdone), .data_byte_address_o(da),
        .data_periph_o(periph), .data_lcd_o(lcd), .gpr_rd_a_o(ga), .gpr_rd_b_o(gb),
        .spr_rd_o(sp), .bt_div_sel_o(bt), .wdt_enable_o(wdt));
    cag_prog_mem cag_prog_mem_i (.mclk_i(mclk_i), .blank_i(blank), .opt_lo_i(16'h0000),
        .opt_hi_i(16'hA7FF), .addr_i(pa), .rdata_o(prog_rdata_i));

    // ==========
    // result watcher
    always @(negedge mclk_i) begin
        if (q_sel.size() > 0) begin
            case (q_sel[0])
                3'h0: got = avs_readdata_o;
                3'h1: got = {12'h0, pa};
                3'h2: got = {16'h0, da};
                3'h3: got = {30'h0, periph, lcd};
                3'h4: got = {24'h0, ga};
                3'h5: got = {24'h0, gb};
                3'h6: got = {27'h0, bt, wdt, bdone};
                default: got = {23'h0, sp, oor};
            endcase
            n_compared++;
            if (got !== q_exp[0]) begin
                n_fail++;
                $display("Error at %0t: kind %0d got %h want %h", $time, q_sel[0], got, q_exp[0]);
            end
            void'(q_sel.pop_front());
            void'(q_exp.pop_front());
        end
    end

    // ==========
    // drivers
    function automatic logic [7:0] rnd8();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs[7:0];
    endfunction

    task automatic note(input logic [2:0] s, input logic [31:0] e);
        q_sel.push_back(s);
        q_exp.push_back(e);
        @(posedge mclk_i);
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        logic w;
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(negedge mclk_i);
            w = avs_waitrequest_o;
            @(posedge mclk_i);
        end while (w !== 1'b0);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic pc(input cag_pkg::cag_pc_op_t op, input logic [19:0] t, input logic [19:0] e);
        @(posedge mclk_i);
        pc_cmd_i <= '{op, t};
        @(posedge mclk_i);
        pc_cmd_i <= '0;
        note(3'h1, {12'h0, e});
    endtask

    task automatic dat(input logic ix, sec, md, input logic [7:0] dl, a, input logic [15:0] e);
        @(posedge mclk_i);
        data_cmd_i <= '{1'b1, ix, sec, md, dl, a};
        @(posedge mclk_i);
        data_cmd_i <= '0;
        note(3'h2, {16'h0, e});
        note(3'h3, {30'h0, e <= 16'h007F, e >= 16'h0200 && e <= 16'h020F});
    endtask

    task automatic rf(input cag_pkg::cag_rf_cmd_t c);
        @(posedge mclk_i);
        rf_cmd_i <= c;
        @(posedge mclk_i);
        // read selects stay, so registered reads keep showing the same register
        rf_cmd_i.wr_en <= 1'b0;
        rf_cmd_i.to_spr <= 1'b0;
        rf_cmd_i.from_spr <= 1'b0;
    endtask

    task automatic boot();
        sys_rst_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk_i);
        n_fail++;
        $display("Error at %0t: run did not finish", $time);
        complete_run();
    end

    // ==========
    // scenarios
    initial begin
        cag_pkg::cag_rf_cmd_t c;
        boot();
        note(3'h6, {27'h0, 3'h2, 1'b0, 1'b1});
        bus(1'b0, 4'hC, 32'h0);
        note(3'h0, 32'hA7FF0000);
        $display("boot options test done");
        pc(cag_pkg::CAG_PC_LONG, 20'h047AC, 20'h047AC);
        pc(cag_pkg::CAG_PC_LONG, 20'hA507F, 20'hA507F);
        pc(cag_pkg::CAG_PC_LONG, 20'h5EFFF, 20'h5EFFF);
        pc(cag_pkg::CAG_PC_SEQ, 20'h00000, 20'h5E000);
        pc(cag_pkg::CAG_PC_LONG, 20'h6FFFE, 20'h6FFFE);
        pc(cag_pkg::CAG_PC_REL, 20'h00005, 20'h6F003);
        note(3'h7, 32'h1);
        pc(cag_pkg::CAG_PC_VEC, 20'h00007, 20'h00004);
        pc(cag_pkg::CAG_PC_LONG, 20'h01FFF, 20'h01FFF);
        note(3'h7, 32'h0);
        bus(1'b1, 4'h4, 32'h000FFFFF);
        bus(1'b0, 4'h4, 32'h0);
        note(3'h0, 32'h00001FFF);
        bus(1'b0, 4'h2, 32'h0);
        note(3'h0, 32'h0);
        $display("program counter test done");
        bus(1'b1, 4'h8, 32'h000F00FC);
        dat(1'b1, 1'b0, 1'b1, 8'h05, 8'h00, 16'h0FFC);
        bus(1'b0, 4'h8, 32'h0);
        note(3'h0, 32'h00100001);
        dat(1'b1, 1'b1, 1'b0, 8'h00, 8'h00, 16'h1000);
        a8 = rnd8();
        dat(1'b0, 1'b0, 1'b0, 8'h00, a8, {8'h00, a8});
        bus(1'b1, 4'h0, 32'h00000001);
        dat(1'b0, 1'b0, 1'b0, 8'h00, 8'h05, 16'h1005);
        bus(1'b1, 4'h0, 32'h00000005);
        bus(1'b0, 4'h8, 32'h0);
        note(3'h0, 32'h0);
        bus(1'b1, 4'h8, 32'h00020005);
        dat(1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 16'h0205);
        bus(1'b1, 4'h0, 32'h00000000);
        dat(1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 16'h1001);
        $display("data address test done");
        for (int b = 0; b < 4; b++) begin
            bus(1'b1, 4'h0, {27'h0, b[1:0], 3'h0});
            gv[b] = rnd8();
            c = '0;
            c.wr_en = 1'b1;
            c.wr_sel = 2'h1;
            c.wr_data = gv[b];
            rf(c);
        end
        for (int b = 0; b < 4; b++) begin
            bus(1'b1, 4'h0, {27'h0, b[1:0], 3'h0});
            c = '0;
            c.rd_a = 2'h1;
            c.rd_b = 2'h1;
            rf(c);
            note(3'h4, {24'h0, gv[b]});
            note(3'h5, {24'h0, gv[b]});
        end
        c = '0;
        c.to_spr = 1'b1;
        c.special_register = cag_pkg::CAG_SPR_IDH;
        c.rd_a = 2'h1;
        rf(c);
        c = '0;
        c.from_spr = 1'b1;
        c.special_register = cag_pkg::CAG_SPR_IDH;
        c.rd_a = 2'h2;
        rf(c);
        note(3'h7, {23'h0, gv[3], 1'b0});
        c = '0;
        c.rd_a = 2'h2;
        rf(c);
        note(3'h4, {24'h0, gv[3]});
        $display("register bank test done");
        blank <= 1'b1;
        boot();
        note(3'h6, {27'h0, 3'h7, 1'b1, 1'b1});
        bus(1'b0, 4'hC, 32'h0);
        note(3'h0, 32'hFFFFFFFF);
        $display("blank option test done");
        @(posedge mclk_i);
        complete_run();
    end
endmodule
